// [dv/ftol_meas_model.sv]
// Purpose: Measurement source that answers each sample request.
// Assumes: Shares the block clock; answers delay_in+2 cycles after a request.
// Notes:   Data lines toggle outside the valid cycle so stale data never passes.
`timescale 1ns/1ps
`default_nettype none
module ftol_meas_model
  import ftol_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  // Test control.
  input  wire logic [7:0]    delay_in,
  input  wire logic [VW-1:0] field_in,
  input  wire logic [VW-1:0] temp_in,
  // Link to the block.
  input  wire logic          req_in,
  output logic               valid_out,
  output logic      [VW-1:0] field_out,
  output logic      [VW-1:0] temp_out
);
  logic       busy_q;
  logic [7:0] cnt_q;

  initial begin
    valid_out = 1'b0;
    field_out = 24'h5a5a5a;
    temp_out  = 24'h3c3c3c;
  end

  always @(posedge clk_in) begin
    valid_out <= 1'b0;
    field_out <= ~field_out;
    temp_out  <= ~temp_out;
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else if (busy_q && cnt_q == 8'h00) begin
      valid_out <= 1'b1;
      field_out <= field_in;
      temp_out  <= temp_in;
      busy_q    <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (req_in) begin
      busy_q <= 1'b1;
      cnt_q  <= delay_in;
    end
  end
endmodule : ftol_meas_model
`default_nettype wire

// [dv/ftol_top_test.sv]
// Purpose: Self-checking bench for the threshold output block.
// Assumes: Interval counts shortened through MS_CYCLES.
// Notes:   Requests are counted on the falling edge to avoid races.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module ftol_top_test;
  import ftol_pkg::*;
  localparam int MS = 4;
  logic        sys_clk, rst_n, rd, wr, req, valid, pin, wait_r;
  logic [7:0]  adr, dly;
  logic [31:0] wdat, rdat, q;
  logic [23:0] fld, tmp, mf, foff, toff;
  int          n_fail, compares, n_req, n_done, cyc;
  // Entries: mode, threshold a, threshold b, field, expected pin.
  localparam logic [74:0] TBL [15] = '{
    {2'h1, 24'h800000, 24'h000000, 24'h800001, 1'b1},
    {2'h1, 24'h800000, 24'h000000, 24'h800000, 1'b0},
    {2'h1, 24'h800000, 24'h000000, 24'h7fffff, 1'b0},
    {2'h1, 24'h800000, 24'h000000, 24'hffffff, 1'b1},
    {2'h2, 24'h800000, 24'h000000, 24'h7fffff, 1'b1},
    {2'h2, 24'h800000, 24'h000000, 24'h800000, 1'b0},
    {2'h2, 24'h800000, 24'h000000, 24'h800001, 1'b0},
    {2'h3, 24'hc00000, 24'h400000, 24'hc00001, 1'b1},
    {2'h3, 24'hc00000, 24'h400000, 24'h800000, 1'b0},
    {2'h3, 24'hc00000, 24'h400000, 24'h3fffff, 1'b1},
    {2'h3, 24'hc00000, 24'h400000, 24'h400000, 1'b0},
    {2'h3, 24'h400000, 24'hc00000, 24'h800000, 1'b1},
    {2'h3, 24'h400000, 24'hc00000, 24'hc00000, 1'b0},
    {2'h3, 24'h400000, 24'hc00000, 24'h000000, 1'b0},
    {2'h0, 24'h400000, 24'hc00000, 24'h800000, 1'b0}};

  ftol_top #(.MS_CYCLES(MS)) ftol_top_i (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_r),
    .meas_req_out(req), .meas_valid_in(valid), .meas_field_in(fld),
    .meas_temp_in(tmp), .field_offset_out(foff), .temp_offset_out(toff),
    .thr_pin_out(pin));

  ftol_meas_model ftol_meas_model_i (
    .clk_in(sys_clk), .rst_n_in(rst_n), .delay_in(dly), .field_in(mf),
    .temp_in(24'h123456), .req_in(req), .valid_out(valid),
    .field_out(fld), .temp_out(tmp));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    cyc++;
    if (req === 1'b1) n_req++;
    if (valid === 1'b1) n_done++;
  end

  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // One bus access; read data lands in q at the completing edge.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    rd   <= !w;
    wr   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    #1;
    `CHK("bus answer", 1'b1, n < 20)
  endtask : acc

  task automatic meas_wait;
    int k, r;
    r = n_done;
    k = 0;
    while (n_done == r && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    #1;
    `CHK("sample done", 1'b1, n_done != r)
  endtask : meas_wait

  task automatic t_reset;
    acc(0, ADR_THA, 0); `CHK("thr_a", 32'h00c00000, q)
    acc(0, ADR_THB, 0); `CHK("thr_b", 32'h00400000, q)
    acc(0, ADR_CFG, 0); `CHK("config", 32'h00000007, q)
    acc(0, ADR_STAT, 0); `CHK("status", 32'h0, q)
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    acc(1, ADR_FOFF, 32'h00800123); `CHK("foff", 24'h800123, foff)
    acc(1, ADR_TOFF, 32'h00ffffff); `CHK("toff", 24'hffffff, toff)
    acc(0, ADR_FOFF, 0); `CHK("foff read", 32'h00800123, q)
    acc(1, 8'h40, 32'hffffa5c3);
    acc(1, 8'ha4, 32'h12343c5a);
    acc(0, 8'h40, 0); `CHK("user 0", 32'h0000a5c3, q)
    acc(0, 8'ha4, 0); `CHK("user 25", 32'h00003c5a, q)
    acc(1, 8'hfc, 32'h1);
    acc(0, 8'hfc, 0); `CHK("unmapped", 32'h0, q)
    $display("test registers done");
  endtask : t_regs

  task automatic t_modes;
    logic p;
    foreach (TBL[i]) begin
      p = pin;
      acc(1, ADR_CFG, {27'h0, 3'h1, TBL[i][74:73]});
      acc(1, ADR_THA, {8'h0, TBL[i][72:49]});
      acc(1, ADR_THB, {8'h0, TBL[i][48:25]});
      mf = TBL[i][24:1];
      `CHK("pin held", p, pin)
      acc(1, ADR_CMD, CMD_SINGLE);
      meas_wait();
      `CHK("pin", TBL[i][0], pin)
    end
    $display("test compare modes done");
  endtask : t_modes

  task automatic t_normal;
    int r;
    acc(1, ADR_CFG, 32'h00000005);
    acc(1, ADR_THA, 32'h00800000);
    mf = 24'hffffff;
    r = n_req;
    repeat (40) @(posedge sys_clk);
    `CHK("pin idle", 1'b0, pin)
    `CHK("no request", r, n_req)
    acc(0, ADR_FIELD, 0); `CHK("old field", 32'h00800000, q)
    meas_wait();
    `CHK("pin on read", 1'b1, pin)
    acc(0, ADR_TEMP, 0); `CHK("temp", 32'h00123456, q)
    acc(0, ADR_FIELD, 0); `CHK("new field", 32'h00ffffff, q)
    meas_wait();
    $display("test normal mode done");
  endtask : t_normal

  task automatic t_cyclic;
    int iv, t0, r;
    dly = 8'h06;
    for (int i = 1; i < 7; i++) begin
      iv = (MS * 125) << (i - 1);
      mf = i[0] ? 24'h000000 : 24'hffffff;
      acc(1, ADR_CFG, {27'h0, 3'(i), 2'h1});
      acc(1, ADR_CMD, CMD_CYC_START);
      t0 = cyc;
      r = n_req;
      if (i == 1) begin
        acc(0, ADR_STAT, 0); `CHK("cyclic", 1'b1, q[0])
        acc(0, ADR_THA, 0); `CHK("refused read", 32'h0, q)
        acc(1, ADR_THA, 32'h00000010);
        acc(0, ADR_STAT, 0); `CHK("refused", 1'b1, q[3])
      end
      while (n_req == r && cyc - t0 < iv + 40) @(posedge sys_clk);
      `CHK("interval", 1'b1, cyc - t0 >= iv - 8 && cyc - t0 <= iv + 8)
      meas_wait();
      `CHK("pin cyclic", !i[0], pin)
      acc(1, ADR_CMD, CMD_CYC_STOP);
    end
    r = n_req;
    repeat (600) @(posedge sys_clk);
    `CHK("stopped", r, n_req)
    acc(0, ADR_STAT, 0); `CHK("cyclic off", 1'b0, q[0])
    acc(0, ADR_THA, 0); `CHK("thr kept", 32'h00800000, q)
    acc(1, ADR_STAT, 32'h00000008);
    acc(0, ADR_STAT, 0); `CHK("refused clr", 1'b0, q[3])
    $display("test cyclic mode done");
  endtask : t_cyclic

  initial begin
    repeat (50000) @(posedge sys_clk);
    n_fail++;
    $display("CHECK FAILED watchdog expired");
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    rd    = 1'b0;
    wr    = 1'b0;
    adr   = 8'h00;
    wdat  = 32'h0;
    dly   = 8'h01;
    mf    = 24'h800000;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK("pin reset", 1'b0, pin)
    t_reset();
    t_regs();
    t_modes();
    t_normal();
    t_cyclic();
    tally_and_finish();
  end
endmodule : ftol_top_test
`default_nettype wire

// [logic/ftol_compare.sv]
// Purpose: Threshold decision for one field measurement.
// Assumes: Unsigned 24-bit operands, mid-scale is zero field.
// Notes:   Equal values never satisfy a comparison.
`timescale 1ns/1ps
`default_nettype none
module ftol_compare
  import ftol_pkg::*;
(
  ftol_cmp_if.cmp cmp_if
);

  always_comb begin
    case (cmp_if.mode)
      CMP_HIGH: cmp_if.hit = cmp_if.field > cmp_if.thr_a;
      CMP_LOW:  cmp_if.hit = cmp_if.field < cmp_if.thr_a;
      CMP_WIN: begin
        if (cmp_if.thr_a > cmp_if.thr_b) begin
          cmp_if.hit = (cmp_if.field > cmp_if.thr_a) ||
                       (cmp_if.field < cmp_if.thr_b);
        end else begin
          // Equal thresholds leave an empty window, so the pin stays low.
          cmp_if.hit = (cmp_if.field > cmp_if.thr_a) &&
                       (cmp_if.field < cmp_if.thr_b);
        end
      end
      default:  cmp_if.hit = 1'b0;
    endcase
  end

endmodule : ftol_compare
`default_nettype wire

// [logic/ftol_top.sv]
// Purpose: Parameter store, measurement sequencing and threshold pin.
// Assumes: Measurement source shares sys_clk_in and answers each request.
// Notes:   Retained storage is modelled by flip-flops with factory values.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module ftol_top
  import ftol_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
  // Clock and reset.
  input  wire logic          sys_clk_in,
  input  wire logic          rst_n_in,
  // Avalon-MM slave.
  input  wire logic [AW-1:0] avs_address_in,
  input  wire logic          avs_read_in,
  input  wire logic          avs_write_in,
  input  wire logic [DW-1:0] avs_writedata_in,
  output logic      [DW-1:0] avs_readdata_out,
  output logic               avs_waitrequest_out,
  // Measurement source.
  output logic               meas_req_out,
  input  wire logic          meas_valid_in,
  input  wire logic [VW-1:0] meas_field_in,
  input  wire logic [VW-1:0] meas_temp_in,
  // Calibration values for the signal chain.
  output logic      [VW-1:0] field_offset_out,
  output logic      [VW-1:0] temp_offset_out,
  // Threshold pin.
  output logic               thr_pin_out
);

  localparam int unsigned DIV_W = $clog2(MS_CYCLES);

  if (MS_CYCLES < 2) begin : g_bad_div
    $error("MS_CYCLES must be at least 2");
  end

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

  typedef struct packed {
    ftol_st_t                      st;
    logic                          wreq;
    logic [DW-1:0]                 rdata;
    logic                          req;
    logic                          pend;
    logic                          cyc;
    logic                          refused;
    logic [DIV_W-1:0]              div;
    logic [11:0]                   ms;
    logic                          dout;
    logic [VW-1:0]                 field;
    logic [VW-1:0]                 temp;
    logic [VW-1:0]                 foff;
    logic [VW-1:0]                 toff;
    logic [VW-1:0]                 thr_a;
    logic [VW-1:0]                 thr_b;
    ftol_mode_t                    mode;
    logic [2:0]                    icode;
    logic [USER_WORDS-1:0][UW-1:0] user;
  } ftol_state_t;

  // Factory values stand in for the retained store at power-up.
  localparam ftol_state_t S_RST = '{
    st:      ST_IDLE,
    wreq:    1'b1,
    mode:    DEF_MODE,
    thr_a:   DEF_THR_A,
    thr_b:   DEF_THR_B,
    foff:    DEF_FOFF,
    toff:    DEF_TOFF,
    icode:   DEF_ICODE,
    default: '0
  };

  ftol_state_t s_q;
  ftol_state_t s_d;

  logic       bus_req;
  logic       acc;
  logic       is_param;
  logic       blocked;
  logic       user_hit;
  logic [7:0] user_off;
  logic [4:0] user_idx;
  logic       commit;

  ftol_cmp_if cif ();

  ftol_compare ftol_compare_i (
    .cmp_if (cif)
  );

  assign cif.field = meas_field_in;
  assign cif.thr_a = s_q.thr_a;
  assign cif.thr_b = s_q.thr_b;
  assign cif.mode  = s_q.mode;

  // A request is seen while waitrequest is high and completes one cycle on.
  assign bus_req  = (avs_read_in | avs_write_in) & s_q.wreq;
  assign acc      = (avs_read_in | avs_write_in) & ~s_q.wreq;
  assign is_param = avs_address_in >= ADR_FOFF;
  assign blocked  = is_param & s_q.cyc;
  assign user_off = avs_address_in - ADR_USER;
  assign user_idx = user_off[6:2];
  assign user_hit = (avs_address_in >= ADR_USER) &&
                    (user_off < USER_SPAN) &&
                    (avs_address_in[1:0] == 2'h0);
  assign commit   = (s_q.st == ST_MEAS) & meas_valid_in;

  always_comb begin
    logic          trig;
    logic [2:0]    code;
    logic [11:0]   ivl;
    logic [DW-1:0] rd;
    trig = 1'b0;
    code = s_q.icode;
    ivl  = INT_BASE_MS;
    rd   = '0;
    s_d  = s_q;
    s_d.req  = 1'b0;
    s_d.wreq = ~bus_req;

    // Unassigned codes are clamped so the rate never passes eight per second.
    if (code < ICODE_MIN) begin
      code = ICODE_MIN;
    end else if (code > ICODE_MAX) begin
      code = ICODE_MAX;
    end
    ivl = INT_BASE_MS << (code - ICODE_MIN);

    // Cyclic sample timer from a one-millisecond enable.
    if (s_q.cyc) begin
      if (s_q.div == DIV_LAST) begin
        s_d.div = '0;
        if (s_q.ms == ivl - 12'h001) begin
          s_d.ms = '0;
          trig   = 1'b1;
        end else begin
          s_d.ms = s_q.ms + 12'h001;
        end
      end else begin
        s_d.div = s_q.div + DIV_W'(1);
      end
    end

    // Read data is prepared while waitrequest is still high.
    if (bus_req && avs_read_in) begin
      case (avs_address_in)
        ADR_STAT: begin
          rd[STAT_CYC]     = s_q.cyc;
          rd[STAT_BUSY]    = s_q.st == ST_MEAS;
          rd[STAT_DOUT]    = s_q.dout;
          rd[STAT_REFUSED] = s_q.refused;
        end
        ADR_FIELD: rd = {8'h00, s_q.field};
        ADR_TEMP:  rd = {8'h00, s_q.temp};
        ADR_FOFF:  rd = {8'h00, s_q.foff};
        ADR_TOFF:  rd = {8'h00, s_q.toff};
        ADR_THA:   rd = {8'h00, s_q.thr_a};
        ADR_THB:   rd = {8'h00, s_q.thr_b};
        ADR_CFG: begin
          rd[CFG_MODE_LSB +: 2]  = s_q.mode;
          rd[CFG_ICODE_LSB +: 3] = s_q.icode;
        end
        default: begin
          if (user_hit) begin
            rd = {16'h0000, s_q.user[user_idx]};
          end
        end
      endcase
      if (blocked) begin
        rd = '0;
      end
      s_d.rdata = rd;
    end

    // A field read is a data request in either mode.
    if (acc && avs_read_in && avs_address_in == ADR_FIELD) begin
      trig = 1'b1;
    end

    if (acc && avs_write_in) begin
      case (avs_address_in)
        ADR_CMD: begin
          case (avs_writedata_in[7:0])
            CMD_SINGLE: trig = 1'b1;
            CMD_CYC_START: begin
              s_d.cyc = 1'b1;
              s_d.div = '0;
              s_d.ms  = '0;
            end
            CMD_CYC_STOP: s_d.cyc = 1'b0;
            default: ;
          endcase
        end
        ADR_STAT: begin
          if (avs_writedata_in[STAT_REFUSED]) begin
            s_d.refused = 1'b0;
          end
        end
        default: begin
          if (!blocked) begin
            case (avs_address_in)
              ADR_FOFF: s_d.foff  = avs_writedata_in[VW-1:0];
              ADR_TOFF: s_d.toff  = avs_writedata_in[VW-1:0];
              ADR_THA:  s_d.thr_a = avs_writedata_in[VW-1:0];
              ADR_THB:  s_d.thr_b = avs_writedata_in[VW-1:0];
              ADR_CFG: begin
                s_d.mode  = ftol_mode_t'(
                  avs_writedata_in[CFG_MODE_LSB +: 2]);
                s_d.icode = avs_writedata_in[CFG_ICODE_LSB +: 3];
              end
              default: begin
                if (user_hit) begin
                  s_d.user[user_idx] = avs_writedata_in[UW-1:0];
                end
              end
            endcase
          end
        end
      endcase
    end

    // A refusal seen in the clearing cycle still sets the flag.
    if (acc && blocked) begin
      s_d.refused = 1'b1;
    end

    case (s_q.st)
      ST_IDLE: begin
        if (s_q.pend) begin
          s_d.req  = 1'b1;
          s_d.pend = 1'b0;
          s_d.st   = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (meas_valid_in) begin
          s_d.field = meas_field_in;
          s_d.temp  = meas_temp_in;
          s_d.dout  = cif.hit;
          s_d.st    = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // Requests arriving during a measurement merge into one follow-up.
    if (trig) begin
      s_d.pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_out    = s_q.rdata;
  assign avs_waitrequest_out = s_q.wreq;
  assign meas_req_out        = s_q.req;
  assign field_offset_out    = s_q.foff;
  assign temp_offset_out     = s_q.toff;
  assign thr_pin_out         = s_q.dout;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_cmd_aa;
    acc && avs_write_in && avs_address_in == ADR_CMD &&
    avs_writedata_in[7:0] == CMD_SINGLE &&
    s_q.st == ST_IDLE && !s_q.pend;
  endsequence

  sequence s_issue;
    !meas_req_out ##1 meas_req_out ##1 !meas_req_out;
  endsequence

  property p_single;
    s_cmd_aa |=> s_issue;
  endproperty
  a_single: assert property (p_single)
    else $error("single command did not issue one request");
  property p_hold;
    !commit |=> $stable(thr_pin_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("threshold pin moved without a commit");
  property p_high;
    commit && s_q.mode == CMP_HIGH && meas_field_in > s_q.thr_a
      |=> thr_pin_out;
  endproperty
  a_high: assert property (p_high)
    else $error("high mode did not raise the pin");
  property p_low;
    commit && s_q.mode == CMP_LOW && meas_field_in > s_q.thr_a
      |=> !thr_pin_out;
  endproperty
  a_low: assert property (p_low)
    else $error("inverted mode did not lower the pin");
  property p_win_out;
    commit && s_q.mode == CMP_WIN && s_q.thr_a > s_q.thr_b &&
    meas_field_in < s_q.thr_b |=> thr_pin_out;
  endproperty
  a_win_out: assert property (p_win_out)
    else $error("outer window did not raise the pin");
  property p_win_in;
    commit && s_q.mode == CMP_WIN && s_q.thr_b > s_q.thr_a &&
    meas_field_in <= s_q.thr_a |=> !thr_pin_out;
  endproperty
  a_win_in: assert property (p_win_in)
    else $error("inner window raised the pin outside");
  property p_equal;
    commit && meas_field_in == s_q.thr_a && s_q.mode != CMP_WIN
      |=> !thr_pin_out;
  endproperty
  a_equal: assert property (p_equal)
    else $error("equal measurement raised the pin");
  property p_refuse;
    acc && avs_write_in && s_q.cyc && avs_address_in == ADR_THA
      |=> s_q.refused && $stable(s_q.thr_a);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("parameter write accepted in cyclic mode");
  property p_wait;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  a_wait: assert property (p_wait)
    else $error("waitrequest low for more than one cycle");
  property p_reset;
    disable iff (1'b0)
    !rst_n_in |=> s_q.thr_a == DEF_THR_A && s_q.thr_b == DEF_THR_B &&
                  s_q.mode == DEF_MODE && !s_q.cyc && !thr_pin_out;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not restore defaults");

endmodule : ftol_top
`default_nettype wire

// [pkg/ftol_cmp_if.sv]
// Purpose: Carries a measurement and threshold set to the comparator.
// Assumes: Purely combinational use on one clock.
// Notes:   The controller drives the operands and reads the decision.
`timescale 1ns/1ps
`default_nettype none
interface ftol_cmp_if;
  import ftol_pkg::*;
  logic [VW-1:0] field;
  logic [VW-1:0] thr_a;
  logic [VW-1:0] thr_b;
  logic [1:0]    mode;
  logic          hit;
  modport ctrl (output field, thr_a, thr_b, mode, input hit);
  modport cmp  (input field, thr_a, thr_b, mode, output hit);
endinterface : ftol_cmp_if
`default_nettype wire

// [pkg/ftol_pkg.sv]
// Purpose: Shared constants and types of the threshold output block.
// Assumes: 25 MHz system clock, Avalon-MM slave with 8-bit byte address.
// Notes:   All offsets are byte addresses of aligned 32-bit words.
package ftol_pkg;

  // Timing.
  localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_FREQ_HZ / MS_PER_S;
  localparam logic [11:0] INT_BASE_MS   = 12'h07d;
  localparam logic [2:0]  ICODE_MIN     = 3'h1;
  localparam logic [2:0]  ICODE_MAX     = 3'h6;

  // Widths and sizes.
  localparam int unsigned AW            = 8;
  localparam int unsigned DW            = 32;
  localparam int unsigned VW            = 24;
  localparam int unsigned UW            = 16;
  localparam int unsigned USER_WORDS    = 26;
  localparam int unsigned SIGN_BIT      = 23;

  // Register map.
  localparam logic [7:0]  ADR_CMD       = 8'h00;
  localparam logic [7:0]  ADR_STAT      = 8'h04;
  localparam logic [7:0]  ADR_FIELD     = 8'h08;
  localparam logic [7:0]  ADR_TEMP      = 8'h0c;
  localparam logic [7:0]  ADR_FOFF      = 8'h10;
  localparam logic [7:0]  ADR_TOFF      = 8'h14;
  localparam logic [7:0]  ADR_THA       = 8'h18;
  localparam logic [7:0]  ADR_THB       = 8'h1c;
  localparam logic [7:0]  ADR_CFG       = 8'h20;
  localparam logic [7:0]  ADR_USER      = 8'h40;
  localparam logic [7:0]  USER_SPAN     = 8'h68;

  // Field positions.
  localparam int unsigned STAT_CYC      = 0;
  localparam int unsigned STAT_BUSY     = 1;
  localparam int unsigned STAT_DOUT     = 2;
  localparam int unsigned STAT_REFUSED  = 3;
  localparam int unsigned CFG_MODE_LSB  = 0;
  localparam int unsigned CFG_ICODE_LSB = 2;

  // Commands.
  localparam logic [7:0]  CMD_SINGLE    = 8'haa;
  localparam logic [7:0]  CMD_CYC_START = 8'hab;
  localparam logic [7:0]  CMD_CYC_STOP  = 8'hbf;

  typedef enum logic [1:0] {
    CMP_OFF  = 2'h0,
    CMP_HIGH = 2'h1,
    CMP_LOW  = 2'h2,
    CMP_WIN  = 2'h3
  } ftol_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MEAS = 2'b10
  } ftol_st_t;

  // Factory defaults.
  localparam ftol_mode_t  DEF_MODE      = CMP_WIN;
  localparam logic [23:0] DEF_THR_A     = 24'hc00000;
  localparam logic [23:0] DEF_THR_B     = 24'h400000;
  localparam logic [23:0] DEF_FOFF      = 24'h000000;
  localparam logic [23:0] DEF_TOFF      = 24'h000000;
  localparam logic [2:0]  DEF_ICODE     = 3'h1;

endpackage : ftol_pkg
